// ### rtl/hpp_dev.sv
// hpp_dev: device end of the handshaked parallel port
// assumes configuration inputs are static while the port runs
// What this block does
// - burst: word moves when ready and request meet
// - peripheral holds request asserted when ready
// - transfer clock direction selectable, default per direction
// - ready and request polarity selectable
// - wait delay 0 to 700 ns, 100 ns steps
// - delay also widens gap between transfers
// - input latching captures data on request edge
// - output latching updates pins on request edge
// - active edge from protocol and polarity
// - emulation lines fixed active low
// - emulation is one direction only
// - emulated input: strobe in, buffer-full out
// - emulated output: acknowledge in, ready out
// - emulated output: assert ready, await request
// - peripheral asserts request to take word
// - ready drops on accepting request edge
// - next transfer waits for request release
// - peripheral holds request until word taken
// - delay precedes ready reassertion each word
// - settling delay between back-to-back transfers
// - burst clock speed setting adds 70/140 ns
`timescale 1ns/1ps
`default_nettype none
module hpp_dev
    import hpp_pkg::*;
#(
    parameter int W = 32
) (
    // clocks and reset
    input wire logic i_clk_sys,
    input wire logic i_clk_link,
    input wire logic i_rst_n,
    // configuration
    input wire hpp_mode_t i_mode,
    input wire logic i_dir_out,
    input wire logic i_pclk_rev,
    input wire logic i_ack_pol_hi,
    input wire logic i_req_pol_hi,
    input wire logic i_latch_en,
    input wire logic [DLY_SEL_W-1:0] i_delay_sel,
    input wire logic [1:0] i_speed,
    // words to send
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // words received
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    // connector
    hpp_if.dev lnk
);
    typedef enum {ST_IDLE, ST_WAIT, ST_ACK, ST_HOLD} hpp_st_t;

    logic burst;
    logic emu;
    logic ack_hi;
    logic req_hi;
    logic pclk_drive;
    logic [2:0] s_sync;
    logic [1:0] l_sync;
    logic [W-1:0] din_s;
    logic req_act;
    logic req_act_q;
    logic lead;
    logic trail;
    logic act_edge;
    logic edge_state;
    hpp_st_t st_q;
    logic [6:0] dly_q;
    logic full_q;
    logic tx_tgl_q;
    logic in_ack_q;
    logic [W-1:0] out_word_q;
    logic [W-1:0] pin_q;
    logic [W-1:0] cap_q;
    logic rd_valid_q;
    logic [W-1:0] rd_data_q;
    logic wr_take;
    logic consume;
    logic in_done;
    logic as_ack_act;
    logic pclk_q;
    logic [4:0] div_q;
    logic lk_rdy_q;
    logic lk_room;
    logic lk_xfer;
    logic done_tgl_q;
    logic in_tgl_q;
    logic [W-1:0] lk_dout_q;
    logic [W-1:0] in_word_q;

    // mode decode
    assign burst = (i_mode == HPP_BURST);
    assign emu = (i_mode == HPP_EMU);
    assign ack_hi = hpp_act_hi(i_mode, i_ack_pol_hi);
    assign req_hi = hpp_act_hi(i_mode, i_req_pol_hi);
    // default: receive the clock when sending, drive it when receiving
    assign pclk_drive = (i_dir_out == i_pclk_rev);

    // request line, link toggles and connector data into the system clock
    hpp_sync #(.W(3)) u_sys_sync (
        .i_clk(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_d({lnk.req, done_tgl_q, in_tgl_q}),
        .o_q(s_sync)
    );
    hpp_sync #(.W(W)) u_din_sync (
        .i_clk(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_d(lnk.data),
        .o_q(din_s)
    );

    // edge detection works on the synchronised request only
    assign req_act = (s_sync[2] == req_hi);
    assign lead = req_act & ~req_act_q;
    assign trail = ~req_act & req_act_q;
    // emulation acts on the trailing edge, the level protocol on the leading one
    assign act_edge = emu ? trail : lead;
    assign edge_state = (st_q == ST_ACK) || (st_q == ST_HOLD);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_act_q <= 1'b0;
        end else begin
            req_act_q <= req_act;
        end
    end

    // the word register may not change while the peer still owns the pins
    assign o_wr_ready = ~full_q & (st_q != ST_HOLD);
    assign wr_take = i_wr_valid & o_wr_ready;
    assign consume = ~burst & i_dir_out & (st_q == ST_ACK) & lead;
    assign in_done = ~burst & ~i_dir_out & (st_q == ST_HOLD) & trail;

    // asynchronous handshake sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
            dly_q <= 7'h00;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (!burst && (full_q || !i_dir_out)) begin
                        st_q <= ST_WAIT;
                        // wait states ahead of every ready assertion
                        dly_q <= 7'(i_delay_sel * DLY_STEP_CYC) + GAP_CYC;
                    end
                end
                ST_WAIT: begin
                    if (dly_q == 7'h00) begin
                        st_q <= ST_ACK;
                    end else begin
                        dly_q <= dly_q - 7'h01;
                    end
                end
                ST_ACK: begin
                    if (burst) begin
                        st_q <= ST_IDLE;
                    end else if (lead) begin
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (trail) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ready line meaning; emulated input shows buffer-full, so it is inverted
    always_comb begin
        if (emu && !i_dir_out) begin
            as_ack_act = (st_q != ST_ACK) && (st_q != ST_HOLD);
        end else begin
            as_ack_act = (st_q == ST_ACK);
        end
    end

    // word store and driven pins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            full_q <= 1'b0;
            tx_tgl_q <= 1'b0;
            out_word_q <= '0;
            pin_q <= '0;
        end else begin
            if (wr_take) begin
                full_q <= 1'b1;
                out_word_q <= i_wr_data;
                tx_tgl_q <= tx_tgl_q ^ burst;
            end else if (consume || (burst && full_q && tx_tgl_q == s_sync[1])) begin
                full_q <= 1'b0;
            end
            // unlatched pins follow the word when it is offered
            if (i_dir_out && !i_latch_en && st_q == ST_WAIT && dly_q == 7'h00) begin
                pin_q <= out_word_q;
            end else if (i_dir_out && i_latch_en && act_edge && edge_state) begin
                pin_q <= out_word_q;
            end
        end
    end

    // input capture and delivery of received words
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_q <= '0;
            in_ack_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end else begin
            rd_valid_q <= 1'b0;
            if (i_latch_en && act_edge && edge_state) begin
                cap_q <= din_s;
            end
            if (burst && s_sync[0] != in_ack_q) begin
                rd_valid_q <= 1'b1;
                rd_data_q <= in_word_q;
                in_ack_q <= ~in_ack_q;
            end else if (in_done) begin
                rd_valid_q <= 1'b1;
                // in emulation the active edge is this very edge, so din_s is the latch
                rd_data_q <= (i_latch_en && !emu) ? cap_q : din_s;
            end
        end
    end

    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = rd_data_q;

    // transfer clock divider, always counting; the clock toggles only in burst mode when this end drives it
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pclk_q <= 1'b0;
            div_q <= 5'h00;
        end else if (div_q == 5'h00) begin
            div_q <= hpp_pclk_half(i_speed) - 5'h01;
            pclk_q <= ~pclk_q & burst & pclk_drive;
        end else begin
            div_q <= div_q - 5'h01;
        end
    end

    // burst engine on the shared transfer clock
    hpp_sync #(.W(2)) u_link_sync (
        .i_clk(i_clk_link),
        .i_rst_n(i_rst_n),
        .i_d({tx_tgl_q, in_ack_q}),
        .o_q(l_sync)
    );
    assign lk_room = i_dir_out ? (l_sync[1] != done_tgl_q) : (in_tgl_q == l_sync[0]);
    // request is made on this same clock by the peer, so no synchroniser here
    assign lk_xfer = burst & lk_rdy_q & (lnk.req == req_hi);

    // one word per toggle round trip: simple crossing, traded against throughput
    always_ff @(posedge i_clk_link or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_rdy_q <= 1'b0;
            done_tgl_q <= 1'b0;
            in_tgl_q <= 1'b0;
            lk_dout_q <= '0;
            in_word_q <= '0;
        end else if (lk_xfer) begin
            lk_rdy_q <= 1'b0;
            if (i_dir_out) begin
                done_tgl_q <= ~done_tgl_q;
            end else begin
                in_word_q <= lnk.data;
                in_tgl_q <= ~in_tgl_q;
            end
        end else if (burst && lk_room && !lk_rdy_q) begin
            lk_rdy_q <= 1'b1;
            lk_dout_q <= out_word_q;
        end
    end

    // connector drive
    assign lnk.ack = (burst ? lk_rdy_q : as_ack_act) ~^ ack_hi;
    assign lnk.data_dev_o = burst ? lk_dout_q : pin_q;
    assign lnk.data_dev_oe_n = ~i_dir_out;
    assign lnk.pclk_dev_o = pclk_q;
    assign lnk.pclk_dev_oe_n = ~(burst & pclk_drive);
endmodule
`default_nettype wire

// ### pkg/hpp_pkg.sv
// hpp_pkg: constants, types and decode helpers shared by both port ends
// assumes a 100 MHz system clock at each end
package hpp_pkg;
    localparam int CLK_MHZ = 100;
    // programmable wait delay: 3-bit select, 100 ns per step
    localparam int DLY_SEL_W = 3;
    localparam int DLY_STEP_NS = 100;
    localparam logic [6:0] DLY_STEP_CYC = 7'((DLY_STEP_NS * CLK_MHZ) / 1000);
    // fixed idle gap so a two-flop receiver always sees the ready line move
    localparam logic [6:0] GAP_CYC = 7'h04;
    // transfer clock half period per cable speed setting (least times, rounded up)
    localparam int PCLK_HALF_NS = 50;
    localparam int SPD_MARGIN_NS = 70;
    localparam logic [4:0] PCLK_HALF_CYC0 = 5'((PCLK_HALF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] PCLK_HALF_CYC1 =
        5'(((PCLK_HALF_NS + SPD_MARGIN_NS) * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] PCLK_HALF_CYC2 =
        5'(((PCLK_HALF_NS + 2 * SPD_MARGIN_NS) * CLK_MHZ + 999) / 1000);
    // request pulse width used by the peripheral end
    localparam int STB_PULSE_NS = 500;
    localparam logic [6:0] STB_PULSE_CYC = 7'((STB_PULSE_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic [1:0] {HPP_BURST, HPP_EMU, HPP_LEVEL} hpp_mode_t;

    // emulation mode forces both handshake lines active low
    function automatic logic hpp_act_hi(hpp_mode_t m, logic pol_hi);
        return (m == HPP_EMU) ? 1'b0 : pol_hi;
    endfunction

    // speed 3 is treated as the slowest setting
    function automatic logic [4:0] hpp_pclk_half(logic [1:0] spd);
        case (spd)
            2'h0: return PCLK_HALF_CYC0;
            2'h1: return PCLK_HALF_CYC1;
            default: return PCLK_HALF_CYC2;
        endcase
    endfunction
endpackage

// ### pkg/hpp_if.sv
// hpp_if: connector between the port device and its peripheral
// assumes the bench feeds the resolved pclk back as each end's link clock
`timescale 1ns/1ps
`default_nettype none
interface hpp_if #(
    parameter int W = 32
);
    logic [W-1:0] data_dev_o;
    logic data_dev_oe_n;
    logic [W-1:0] data_peer_o;
    logic data_peer_oe_n;
    logic ack;
    logic req;
    logic pclk_dev_o;
    logic pclk_dev_oe_n;
    logic pclk_peer_o;
    logic pclk_peer_oe_n;
    logic [W-1:0] data;
    logic pclk;

    // resolved shared lines; an undriven line reads low
    assign data = !data_dev_oe_n ? data_dev_o : (!data_peer_oe_n ? data_peer_o : '0);
    assign pclk = !pclk_dev_oe_n ? pclk_dev_o : (!pclk_peer_oe_n ? pclk_peer_o : 1'b0);

    modport dev (
        output data_dev_o, data_dev_oe_n, ack, pclk_dev_o, pclk_dev_oe_n,
        input data, req, pclk
    );
    modport peer (
        output data_peer_o, data_peer_oe_n, req, pclk_peer_o, pclk_peer_oe_n,
        input data, ack, pclk
    );
endinterface
`default_nettype wire

// ### rtl/hpp_sync.sv
// hpp_sync: two-flop synchroniser for levels, toggles and held data
// assumes multi-bit inputs are held stable by a handshake while sampled
`timescale 1ns/1ps
`default_nettype none
module hpp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // foreign-domain input and its synchronised copy
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    // first stage feeds the second only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### rtl/hpp_peer.sv
// hpp_peer: peripheral end, complementary to the device end
// assumes the same mode, direction, polarity and clock-reverse settings as the device
`timescale 1ns/1ps
`default_nettype none
module hpp_peer
    import hpp_pkg::*;
#(
    parameter int W = 32
) (
    // clocks and reset
    input wire logic i_clk_sys,
    input wire logic i_clk_link,
    input wire logic i_rst_n,
    // configuration; i_dir_out is the device's direction
    input wire hpp_mode_t i_mode,
    input wire logic i_dir_out,
    input wire logic i_pclk_rev,
    input wire logic i_pol_hi,
    input wire logic [1:0] i_speed,
    // words to send
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // words received
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    // connector
    hpp_if.peer lnk
);
    typedef enum {PS_IDLE, PS_REQ, PS_REL} hpp_pst_t;

    logic burst;
    logic snd;
    logic hi;
    logic [2:0] s_sync;
    logic [1:0] l_sync;
    logic [W-1:0] din_s;
    logic dev_ready;
    hpp_pst_t st_q;
    logic [6:0] cnt_q;
    logic full_q;
    logic tx_tgl_q;
    logic in_ack_q;
    logic [W-1:0] word_q;
    logic rd_valid_q;
    logic [W-1:0] rd_data_q;
    logic req_done;
    logic pclk_q;
    logic [4:0] div_q;
    logic lk_rdy_q;
    logic lk_room;
    logic lk_xfer;
    logic done_tgl_q;
    logic in_tgl_q;
    logic [W-1:0] lk_dout_q;
    logic [W-1:0] in_word_q;
    logic [1:0] prime_q;

    assign burst = (i_mode == HPP_BURST);
    assign snd = ~i_dir_out;
    assign hi = hpp_act_hi(i_mode, i_pol_hi);

    hpp_sync #(.W(3)) u_sys_sync (
        .i_clk(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_d({lnk.ack, done_tgl_q, in_tgl_q}),
        .o_q(s_sync)
    );
    hpp_sync #(.W(W)) u_din_sync (
        .i_clk(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_d(lnk.data),
        .o_q(din_s)
    );

    // synchronisers reset low, which an active-low line would read as asserted;
    // hold off until the second stage carries the real line level
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prime_q <= 2'h0;
        end else begin
            prime_q <= {prime_q[0], 1'b1};
        end
    end

    // buffer-full from an emulated input means "not ready"
    assign dev_ready = prime_q[1] &
        ((i_mode == HPP_EMU && snd) ? (s_sync[2] != hi) : (s_sync[2] == hi));
    assign req_done = (st_q == PS_REQ) && (snd ? (cnt_q == 7'h00) : !dev_ready);
    assign o_wr_ready = ~full_q;

    // request sequencer: when receiving, hold request until the word is taken and ready drops; when sending, hold it for the pulse width
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= PS_IDLE;
            cnt_q <= 7'h00;
        end else begin
            case (st_q)
                PS_IDLE: begin
                    if (!burst && dev_ready && (full_q || !snd)) begin
                        st_q <= PS_REQ;
                        cnt_q <= STB_PULSE_CYC;
                    end
                end
                PS_REQ: begin
                    cnt_q <= (cnt_q == 7'h00) ? 7'h00 : cnt_q - 7'h01;
                    if (req_done) begin
                        st_q <= PS_REL;
                    end
                end
                PS_REL: begin
                    if (!snd || !dev_ready) begin
                        st_q <= PS_IDLE;
                    end
                end
                default: begin
                    st_q <= PS_IDLE;
                end
            endcase
        end
    end

    // word store, delivery and burst toggles on the system side
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            full_q <= 1'b0;
            tx_tgl_q <= 1'b0;
            in_ack_q <= 1'b0;
            word_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end else begin
            rd_valid_q <= 1'b0;
            if (i_wr_valid && !full_q) begin
                full_q <= 1'b1;
                word_q <= i_wr_data;
                tx_tgl_q <= tx_tgl_q ^ burst;
            end else if ((req_done && snd) || (burst && full_q && tx_tgl_q == s_sync[1])) begin
                full_q <= 1'b0;
            end
            if (burst && s_sync[0] != in_ack_q) begin
                rd_valid_q <= 1'b1;
                rd_data_q <= in_word_q;
                in_ack_q <= ~in_ack_q;
            end else if (req_done && !snd) begin
                rd_valid_q <= 1'b1;
                rd_data_q <= din_s;
            end
        end
    end

    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = rd_data_q;

    // in burst mode this end makes the transfer clock whenever the device does not
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pclk_q <= 1'b0;
            div_q <= 5'h00;
        end else if (div_q == 5'h00) begin
            div_q <= hpp_pclk_half(i_speed) - 5'h01;
            pclk_q <= ~pclk_q & burst & (i_dir_out != i_pclk_rev);
        end else begin
            div_q <= div_q - 5'h01;
        end
    end

    // burst engine, same crossing scheme as the device
    hpp_sync #(.W(2)) u_link_sync (
        .i_clk(i_clk_link),
        .i_rst_n(i_rst_n),
        .i_d({tx_tgl_q, in_ack_q}),
        .o_q(l_sync)
    );
    assign lk_room = snd ? (l_sync[1] != done_tgl_q) : (in_tgl_q == l_sync[0]);
    assign lk_xfer = burst & lk_rdy_q & (lnk.ack == hi);

    always_ff @(posedge i_clk_link or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_rdy_q <= 1'b0;
            done_tgl_q <= 1'b0;
            in_tgl_q <= 1'b0;
            lk_dout_q <= '0;
            in_word_q <= '0;
        end else if (lk_xfer) begin
            lk_rdy_q <= 1'b0;
            if (snd) begin
                done_tgl_q <= ~done_tgl_q;
            end else begin
                in_word_q <= lnk.data;
                in_tgl_q <= ~in_tgl_q;
            end
        end else if (burst && lk_room && !lk_rdy_q) begin
            lk_rdy_q <= 1'b1;
            lk_dout_q <= word_q;
        end
    end

    assign lnk.req = (burst ? lk_rdy_q : (st_q == PS_REQ)) ~^ hi;
    assign lnk.data_peer_o = burst ? lk_dout_q : word_q;
    assign lnk.data_peer_oe_n = ~snd;
    assign lnk.pclk_peer_o = pclk_q;
    assign lnk.pclk_peer_oe_n = ~(burst & (i_dir_out != i_pclk_rev));
endmodule
`default_nettype wire

// ### test/hpp_properties.sv
// hpp_properties: assertions on the connector joining device and peripheral ends
// assumes configuration only changes while reset is held
`timescale 1ns/1ps
`default_nettype none
module hpp_properties
    import hpp_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // configuration
    input wire hpp_mode_t i_mode,
    input wire logic i_dir_out,
    input wire logic i_pclk_rev,
    input wire logic i_pol_hi,
    // connector lines
    input wire logic data_dev_oe_n,
    input wire logic data_peer_oe_n,
    input wire logic ack,
    input wire logic req,
    input wire logic pclk_dev_oe_n,
    input wire logic pclk_peer_oe_n,
    input wire logic [W-1:0] data,
    input wire logic pclk
);
    // emulation lines are active low whatever polarity is set
    wire logic emu_out = (i_mode == HPP_EMU) && i_dir_out;
    wire logic emu_in = (i_mode == HPP_EMU) && !i_dir_out;
    wire logic burst = (i_mode == HPP_BURST);

    a_one_data_drv: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !(!data_dev_oe_n && !data_peer_oe_n)) else $error("both ends drive data");
    a_data_dir_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $past(i_rst_n, 2) |-> data_dev_oe_n == !i_dir_out && data_peer_oe_n == i_dir_out)
        else $error("data direction wrong");
    a_pclk_owner: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        burst && $past(i_rst_n, 2) |-> pclk_dev_oe_n == (i_dir_out ^ i_pclk_rev))
        else $error("transfer clock owner wrong");
    a_one_clk_drv: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !(!pclk_dev_oe_n && !pclk_peer_oe_n)) else $error("both ends drive clock");
    a_emu_ack_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        emu_out && !ack && $fell(req) |-> ##[1:8] ack) else $error("ready not dropped");
    a_emu_hold_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        emu_out && ack && !req |=> ack) else $error("ready back before release");
    a_emu_gap_min: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        emu_out && $rose(req) |=> ack [*4]) else $error("gap too short");
    a_emu_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        emu_in && $fell(req) |=> !req [*8]) else $error("strobe too short");
    // burst lines are flops on the shared clock, so judge them there
    a_burst_move: assert property (@(posedge pclk) disable iff (!i_rst_n)
        burst && ack == i_pol_hi && req == i_pol_hi |=> (i_dir_out ? ack : req) != i_pol_hi)
        else $error("sender ready kept after transfer");
    a_burst_hold: assert property (@(posedge pclk) disable iff (!i_rst_n)
        burst && i_dir_out && ack == i_pol_hi && req != i_pol_hi |=> $stable(data))
        else $error("data moved while waiting");
endmodule
`default_nettype wire

// ### test/tb.sv
// tb: device and peripheral ends back to back, words sent in every mode
// assumes both ends share one configuration, as a real pairing would
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hpp_pkg::*;
    localparam int W = 8;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    hpp_mode_t mode = HPP_BURST;
    logic dir = 1'b0, rev = 1'b0, pol = 1'b0, lat = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [1:0] spd = 2'h0;
    logic dv = 1'b0, pv = 1'b0, dr, pr, drv, prv;
    logic [W-1:0] dd = 8'h00, pd = 8'h00, drd, prd;
    int mismatches = 0;
    int num_checks = 0;

    // free-running system clock
    always #5 i_clk_sys = ~i_clk_sys;

    hpp_if #(.W(W)) lnk ();
    hpp_dev #(.W(W)) i_hpp_dev (.i_clk_sys(i_clk_sys), .i_clk_link(lnk.pclk),
        .i_rst_n(i_rst_n), .i_mode(mode), .i_dir_out(dir), .i_pclk_rev(rev),
        .i_ack_pol_hi(pol), .i_req_pol_hi(pol), .i_latch_en(lat), .i_delay_sel(sel),
        .i_speed(spd), .i_wr_valid(dv), .i_wr_data(dd), .o_wr_ready(dr),
        .o_rd_valid(drv), .o_rd_data(drd), .lnk(lnk.dev));
    hpp_peer #(.W(W)) i_hpp_peer (.i_clk_sys(i_clk_sys), .i_clk_link(lnk.pclk),
        .i_rst_n(i_rst_n), .i_mode(mode), .i_dir_out(dir), .i_pclk_rev(rev),
        .i_pol_hi(pol), .i_speed(spd), .i_wr_valid(pv), .i_wr_data(pd),
        .o_wr_ready(pr), .o_rd_valid(prv), .o_rd_data(prd), .lnk(lnk.peer));
    hpp_properties #(.W(W)) i_hpp_properties (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_mode(mode), .i_dir_out(dir), .i_pclk_rev(rev), .i_pol_hi(pol),
        .data_dev_oe_n(lnk.data_dev_oe_n), .data_peer_oe_n(lnk.data_peer_oe_n),
        .ack(lnk.ack), .req(lnk.req), .pclk_dev_oe_n(lnk.pclk_dev_oe_n),
        .pclk_peer_oe_n(lnk.pclk_peer_oe_n), .data(lnk.data), .pclk(lnk.pclk));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one word from the sending end; n returns cycles from take to delivery
    task automatic send(input logic [W-1:0] w, output int n);
        n = 0;
        @(negedge i_clk_sys);
        if (dir) begin dv = 1'b1; dd = w; end else begin pv = 1'b1; pd = w; end
        // ready comes from flops, so its value at the falling edge holds at the rising one
        while ((dir ? dr : pr) !== 1'b1 && n < 3000) begin @(negedge i_clk_sys); n++; end
        if ((dir ? dr : pr) !== 1'b1) begin check(8'h00, 8'hff); wrap_up(); end
        @(negedge i_clk_sys);
        dv = 1'b0;
        pv = 1'b0;
        n = 1;
        // pulse lasts one cycle, so look at every cycle
        while ((dir ? prv : drv) !== 1'b1 && n < 3000) begin @(negedge i_clk_sys); n++; end
        if (n >= 3000) begin check(8'h00, 8'hff); wrap_up(); end
        check(dir ? prd : drd, w);
    endtask

    // reset with a new configuration, then two words back to back
    task automatic run(input hpp_mode_t m, input logic d, r, p, l, input logic [2:0] s,
            input logic [1:0] sp);
        int n;
        int h;
        @(negedge i_clk_sys);
        i_rst_n = 1'b0;
        mode = m; dir = d; rev = r; pol = p; lat = l; sel = s; spd = sp;
        repeat (20) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        if (m == HPP_EMU && d) check(W'(lnk.ack), 8'h01);
        send(8'ha5, n);
        if (m != HPP_BURST && d) check(W'(n > 10 * s + GAP_CYC), 8'h01);
        send(8'h5a, n);
        if (m == HPP_BURST && d == r) begin
            n = 0;
            // the clock is launched on the rising edge, so look at it half a cycle later
            while (lnk.pclk !== 1'b0 && n < 99) begin @(negedge i_clk_sys); n++; end
            while (lnk.pclk !== 1'b1 && n < 99) begin @(negedge i_clk_sys); n++; end
            h = 0;
            while (lnk.pclk === 1'b1 && h < 99) begin @(negedge i_clk_sys); h++; end
            check(W'(h), W'((50 + 70 * sp + 9) / 10));
        end
    endtask

    // every mode, both directions, both clock owners, polarity and delay corners
    initial begin
        run(HPP_BURST, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 2'h0);
        run(HPP_BURST, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 2'h1);
        run(HPP_BURST, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 2'h2);
        run(HPP_BURST, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 2'h3);
        run(HPP_EMU, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 2'h0);
        run(HPP_EMU, 1'b1, 1'b0, 1'b0, 1'b0, 3'h7, 2'h0);
        run(HPP_EMU, 1'b0, 1'b0, 1'b1, 1'b1, 3'h3, 2'h0);
        run(HPP_LEVEL, 1'b1, 1'b0, 1'b1, 1'b1, 3'h2, 2'h0);
        run(HPP_LEVEL, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h0);
        run(HPP_LEVEL, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5, 2'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
